//--- hdl/tcad_pkg.sv
/*
 * constants for the transmit command word A decoder: field positions,
 * end alignment codes, register map and reset values.
 * assumes: 32-bit command and data words, 32-bit axi4-lite register bus.
 */
package tcad_pkg;

    // command word a fields
    localparam int unsigned CMDA_IRQ_BIT      = 31;
    localparam int unsigned CMDA_RSV_HI_MSB   = 30;
    localparam int unsigned CMDA_RSV_HI_LSB   = 26;
    localparam int unsigned CMDA_ALIGN_MSB    = 25;
    localparam int unsigned CMDA_ALIGN_LSB    = 24;
    localparam int unsigned CMDA_RSV_LO_MSB   = 23;
    localparam int unsigned CMDA_RSV_LO_LSB   = 21;
    localparam int unsigned CMDA_OFFSET_MSB   = 20;
    localparam int unsigned CMDA_OFFSET_LSB   = 16;
    localparam int unsigned CMDA_FIRST_BIT    = 13;
    localparam int unsigned CMDA_LAST_BIT     = 12;
    localparam int unsigned CMDA_SIZE_MSB     = 10;
    localparam int unsigned CMDA_SIZE_LSB     = 0;

    // end alignment codes and the doubleword mask each non-reserved code implies
    localparam logic [1:0]  ALIGN_4B          = 2'h0;
    localparam logic [1:0]  ALIGN_16B         = 2'h1;
    localparam logic [1:0]  ALIGN_32B         = 2'h2;
    localparam logic [1:0]  ALIGN_RSV         = 2'h3;
    localparam logic [11:0] MASK_4B           = 12'h000;
    localparam logic [11:0] MASK_16B          = 12'h003;
    localparam logic [11:0] MASK_32B          = 12'h007;

    // register map, byte addresses
    localparam logic [7:0]  REG_CTRL          = 8'h00;
    localparam logic [7:0]  REG_STATUS        = 8'h04;
    localparam logic [7:0]  REG_LAST_CMDA     = 8'h08;
    localparam logic [7:0]  REG_BUF_COUNT     = 8'h0c;

    // register bits
    localparam int unsigned CTRL_DONE_IRQ_EN  = 0;
    localparam int unsigned STAT_DONE         = 0;
    localparam int unsigned STAT_BAD_ALIGN    = 1;
    localparam int unsigned STAT_BAD_RSV      = 2;
    localparam int unsigned STAT_BUSY         = 3;

    localparam logic        CTRL_RESET        = 1'b0;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    // fifo payload layout: data, lane enables, first/last segment, buffer end
    localparam int unsigned PAY_W             = 39;

    typedef enum logic [1:0] {
        TCAD_S_CMDA = 2'b00,
        TCAD_S_CMDB = 2'b01,
        TCAD_S_DATA = 2'b11
    } tcad_state_t;

endpackage

//--- hdl/tcad_stream_if.sv
/*
 * valid/ready word stream between the decoder and its output fifo.
 * assumes: one clock; a word moves when valid and ready are both high.
 */
`timescale 1ns/1ps
`default_nettype none

interface tcad_stream_if #(
    parameter int unsigned W = 39
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

//--- hdl/tcad_fifo.sv
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes: single clock, synchronous active-low reset, depth a power of two.
 */
`timescale 1ns/1ps
`default_nettype none

module tcad_fifo #(
    parameter int unsigned W     = 39,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    tcad_stream_if.snk  wr,
    tcad_stream_if.src  rd
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    // ready only while a slot is free, so the writer really stalls when full
    assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_r != '0);
    assign rd.data  = mem_r[rp_r];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    // pointer and occupancy next values
    always_comb begin
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop  ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = (AW+1)'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = (AW+1)'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage needs no reset; empty slots are never shown
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_r[wp_r] <= wr.data;
        end
    end
endmodule

`default_nettype wire

//--- hdl/tcad_decoder.sv
/*
 * transmit command word a decoder: takes command words a and b and the
 * buffer data from the host stream, skips start offset bytes, drops the
 * end alignment filler and hands payload words with lane enables to a fifo.
 * assumes: host keeps its own rules on the stream; axi4-lite master on the
 * register port; the consumer drains the fifo through m_* ports.
 */
`timescale 1ns/1ps
`default_nettype none

module tcad_decoder
    import tcad_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 4
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] s_in_data,
    input  wire logic        s_in_valid,
    output logic             s_in_ready,
    output logic [31:0]      m_out_data,
    output logic [3:0]       m_out_lanes,
    output logic             m_out_first_seg,
    output logic             m_out_last_seg,
    output logic             m_out_buf_end,
    output logic             m_out_valid,
    input  wire logic        m_out_ready,
    output logic             host_irq
);

    // doubleword mask for an end alignment code
    function automatic logic [11:0] align_mask(input logic [1:0] code);
        unique case (code)
            ALIGN_16B: align_mask = MASK_16B;
            ALIGN_32B: align_mask = MASK_32B;
            default:   align_mask = MASK_4B;    // reserved code falls back to 4-byte
        endcase
    endfunction

    tcad_stream_if #(.W(PAY_W)) to_fifo ();
    tcad_stream_if #(.W(PAY_W)) from_fifo ();

    // decode state
    tcad_state_t st_r, st_nxt;
    logic        irq_req_r, irq_req_nxt;
    logic [1:0]  align_r, align_nxt;
    logic [4:0]  off_r, off_nxt;
    logic        first_r, first_nxt, last_r, last_nxt;
    logic [10:0] size_r, size_nxt;
    logic [11:0] idx_r, idx_nxt, dend_r, dend_nxt, tot_r, tot_nxt;
    logic [31:0] last_cmda_r, last_cmda_nxt;
    logic [31:0] buf_cnt_r, buf_cnt_nxt;
    logic        done_ev, bad_align_ev, bad_rsv_ev;
    logic        is_pay, take, end_of_buf;
    logic [3:0]  lanes;
    logic [1:0]  lo_lane, hi_lane;
    logic [11:0] fill_end;

    // register state
    logic        ctrl_en_r, ctrl_en_nxt;
    logic [2:0]  stat_r, stat_nxt;
    logic        irq_r, irq_nxt;

    // current word is payload: past the skipped words and before filler
    assign is_pay     = (idx_r >= 12'(off_r[4:2])) && (idx_r < dend_r);
    assign lo_lane    = (idx_r == 12'(off_r[4:2])) ? off_r[1:0] : 2'h0;
    assign fill_end   = 12'(off_r) + 12'(size_r) - 12'h001;
    assign hi_lane    = (idx_r == dend_r - 12'h001) ? fill_end[1:0] : 2'h3;
    assign end_of_buf = (idx_r == tot_r - 12'h001);

    // lane enables from first and last lane of this word
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lanes[i] = (2'(i) >= lo_lane) && (2'(i) <= hi_lane);
        end
    end

    // non-payload words are swallowed at once; payload waits for fifo room
    assign s_in_ready    = (st_r != TCAD_S_DATA) || !is_pay || to_fifo.ready;
    assign take          = s_in_valid && s_in_ready;
    assign to_fifo.valid = (st_r == TCAD_S_DATA) && is_pay && s_in_valid;
    assign to_fifo.data  = {s_in_data, lanes, first_r, last_r, end_of_buf};

    // decode next values
    always_comb begin
        st_nxt        = st_r;
        irq_req_nxt   = irq_req_r;
        align_nxt     = align_r;
        off_nxt       = off_r;
        first_nxt     = first_r;
        last_nxt      = last_r;
        size_nxt      = size_r;
        idx_nxt       = idx_r;
        dend_nxt      = dend_r;
        tot_nxt       = tot_r;
        last_cmda_nxt = last_cmda_r;
        buf_cnt_nxt   = buf_cnt_r;
        done_ev       = 1'b0;
        bad_align_ev  = 1'b0;
        bad_rsv_ev    = 1'b0;
        unique case (st_r)
            TCAD_S_CMDA: begin
                if (take) begin
                    irq_req_nxt   = s_in_data[CMDA_IRQ_BIT];
                    align_nxt     = s_in_data[CMDA_ALIGN_MSB:CMDA_ALIGN_LSB];
                    off_nxt       = s_in_data[CMDA_OFFSET_MSB:CMDA_OFFSET_LSB];
                    first_nxt     = s_in_data[CMDA_FIRST_BIT];
                    last_nxt      = s_in_data[CMDA_LAST_BIT];
                    size_nxt      = s_in_data[CMDA_SIZE_MSB:CMDA_SIZE_LSB];
                    last_cmda_nxt = s_in_data;
                    bad_align_ev  = (s_in_data[CMDA_ALIGN_MSB:CMDA_ALIGN_LSB]
                                     == ALIGN_RSV);
                    bad_rsv_ev    = (s_in_data[CMDA_RSV_HI_MSB:CMDA_RSV_HI_LSB] != '0)
                                 || (s_in_data[CMDA_RSV_LO_MSB:CMDA_RSV_LO_LSB] != '0);
                    st_nxt        = TCAD_S_CMDB;
                end
            end
            TCAD_S_CMDB: begin
                // word b is left to the packet checker; only lengths are set up
                if (take) begin
                    dend_nxt = 12'((12'(off_r) + 12'(size_r) + 12'h003) >> 2);
                    tot_nxt  = (dend_nxt + align_mask(align_r))
                             & ~align_mask(align_r);
                    idx_nxt  = '0;
                    if (tot_nxt == '0) begin
                        // empty buffer with no offset: nothing follows the commands
                        st_nxt      = TCAD_S_CMDA;
                        done_ev     = irq_req_r;
                        buf_cnt_nxt = buf_cnt_r + 32'h1;
                    end else begin
                        st_nxt = TCAD_S_DATA;
                    end
                end
            end
            TCAD_S_DATA: begin
                if (take) begin
                    idx_nxt = 12'(idx_r + 12'h001);
                    if (end_of_buf) begin
                        // flag only after the last word, filler included, is in
                        st_nxt      = TCAD_S_CMDA;
                        done_ev     = irq_req_r;
                        buf_cnt_nxt = buf_cnt_r + 32'h1;
                    end
                end
            end
            default: begin
                st_nxt = TCAD_S_CMDA;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r        <= TCAD_S_CMDA;
            irq_req_r   <= 1'b0;
            align_r     <= ALIGN_4B;
            off_r       <= '0;
            first_r     <= 1'b0;
            last_r      <= 1'b0;
            size_r      <= '0;
            idx_r       <= '0;
            dend_r      <= '0;
            tot_r       <= '0;
            last_cmda_r <= '0;
            buf_cnt_r   <= '0;
        end else begin
            st_r        <= st_nxt;
            irq_req_r   <= irq_req_nxt;
            align_r     <= align_nxt;
            off_r       <= off_nxt;
            first_r     <= first_nxt;
            last_r      <= last_nxt;
            size_r      <= size_nxt;
            idx_r       <= idx_nxt;
            dend_r      <= dend_nxt;
            tot_r       <= tot_nxt;
            last_cmda_r <= last_cmda_nxt;
            buf_cnt_r   <= buf_cnt_nxt;
        end
    end

    tcad_fifo #(
        .W     (PAY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr      (to_fifo.snk),
        .rd      (from_fifo.src)
    );

    assign from_fifo.ready = m_out_ready;
    assign m_out_valid     = from_fifo.valid;
    assign m_out_data      = from_fifo.data[38:7];
    assign m_out_lanes     = from_fifo.data[6:3];
    assign m_out_first_seg = from_fifo.data[2];
    assign m_out_last_seg  = from_fifo.data[1];
    assign m_out_buf_end   = from_fifo.data[0];

    // axi4-lite write side: address and data latched in either order
    logic        awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt;
    logic        awh_r, awh_nxt, wh_r, wh_nxt;
    logic [7:0]  awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [3:0]  ws_r, ws_nxt;
    logic [1:0]  br_r, br_nxt;
    logic        do_wr, w1c_done, w1c_align, w1c_rsv;

    assign do_wr     = awh_r && wh_r && !bv_r;
    assign w1c_done  = do_wr && (awa_r == REG_STATUS) && ws_r[0] && wd_r[STAT_DONE];
    assign w1c_align = do_wr && (awa_r == REG_STATUS) && ws_r[0] && wd_r[STAT_BAD_ALIGN];
    assign w1c_rsv   = do_wr && (awa_r == REG_STATUS) && ws_r[0] && wd_r[STAT_BAD_RSV];

    always_comb begin
        awh_nxt     = awh_r;
        wh_nxt      = wh_r;
        awa_nxt     = awa_r;
        wd_nxt      = wd_r;
        ws_nxt      = ws_r;
        bv_nxt      = bv_r;
        br_nxt      = br_r;
        ctrl_en_nxt = ctrl_en_r;
        if (s_axi_awvalid && awr_r) begin
            awh_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wr_r) begin
            wh_nxt = 1'b1;
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
        end
        if (do_wr) begin
            awh_nxt = 1'b0;
            wh_nxt  = 1'b0;
            bv_nxt  = 1'b1;
            br_nxt  = RESP_OKAY;
            unique case (awa_r)
                REG_CTRL: begin
                    if (ws_r[0]) begin
                        ctrl_en_nxt = wd_r[CTRL_DONE_IRQ_EN];
                    end
                end
                REG_STATUS, REG_LAST_CMDA, REG_BUF_COUNT: begin
                    br_nxt = RESP_OKAY;
                end
                default: begin
                    br_nxt = RESP_SLVERR;
                end
            endcase
        end
        if (bv_r && s_axi_bready) begin
            bv_nxt = 1'b0;
        end
        awr_nxt = !awh_nxt && !bv_nxt;
        wr_nxt  = !wh_nxt && !bv_nxt;
        // sticky flags: a new event wins over a clear in the same cycle
        stat_nxt[STAT_DONE]      = done_ev || (stat_r[STAT_DONE] && !w1c_done);
        stat_nxt[STAT_BAD_ALIGN] = bad_align_ev || (stat_r[STAT_BAD_ALIGN] && !w1c_align);
        stat_nxt[STAT_BAD_RSV]   = bad_rsv_ev || (stat_r[STAT_BAD_RSV] && !w1c_rsv);
        irq_nxt = stat_nxt[STAT_DONE] && ctrl_en_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awr_r     <= 1'b0;
            wr_r      <= 1'b0;
            awh_r     <= 1'b0;
            wh_r      <= 1'b0;
            awa_r     <= '0;
            wd_r      <= '0;
            ws_r      <= '0;
            bv_r      <= 1'b0;
            br_r      <= RESP_OKAY;
            ctrl_en_r <= CTRL_RESET;
            stat_r    <= '0;
            irq_r     <= 1'b0;
        end else begin
            awr_r     <= awr_nxt;
            wr_r      <= wr_nxt;
            awh_r     <= awh_nxt;
            wh_r      <= wh_nxt;
            awa_r     <= awa_nxt;
            wd_r      <= wd_nxt;
            ws_r      <= ws_nxt;
            bv_r      <= bv_nxt;
            br_r      <= br_nxt;
            ctrl_en_r <= ctrl_en_nxt;
            stat_r    <= stat_nxt;
            irq_r     <= irq_nxt;
        end
    end

    assign s_axi_awready = awr_r;
    assign s_axi_wready  = wr_r;
    assign s_axi_bvalid  = bv_r;
    assign s_axi_bresp   = br_r;
    assign host_irq      = irq_r;

    // axi4-lite read side: one outstanding read, data registered
    logic        arr_r, arr_nxt, rv_r, rv_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0]  rr_r, rr_nxt;

    always_comb begin
        rv_nxt  = rv_r;
        rd_nxt  = rd_r;
        rr_nxt  = rr_r;
        if (s_axi_arvalid && arr_r) begin
            rv_nxt = 1'b1;
            rr_nxt = RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL:      rd_nxt = {31'h0, ctrl_en_r};
                REG_STATUS:    rd_nxt = {28'h0, st_r != TCAD_S_CMDA, stat_r};
                REG_LAST_CMDA: rd_nxt = last_cmda_r;
                REG_BUF_COUNT: rd_nxt = buf_cnt_r;
                default: begin
                    rd_nxt = '0;
                    rr_nxt = RESP_SLVERR;
                end
            endcase
        end else if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
        arr_nxt = !rv_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arr_r <= 1'b0;
            rv_r  <= 1'b0;
            rd_r  <= '0;
            rr_r  <= RESP_OKAY;
        end else begin
            arr_r <= arr_nxt;
            rv_r  <= rv_nxt;
            rd_r  <= rd_nxt;
            rr_r  <= rr_nxt;
        end
    end

    assign s_axi_arready = arr_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rdata   = rd_r;
    assign s_axi_rresp   = rr_r;

endmodule

`default_nettype wire

//--- test/tcad_host_model.sv
/* host side model: streams command words and buffer words to the decoder.
   assumes: the bench fills q; slow adds random idle cycles. */
`timescale 1ns/1ps
`default_nettype none
module tcad_host_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    output logic [31:0]      s_in_data,
    output logic             s_in_valid,
    input  wire logic        s_in_ready
);
    logic [31:0] q[$];
    bit          slow;
    initial begin
        s_in_data  = 32'h0;
        s_in_valid = 1'b0;
    end
    // word held until taken; idle data toggles so nothing stale looks valid
    // q may carry nonzero reserved fields, the reserved align code and filler
    always @(posedge aclk) begin
        if (aresetn && s_in_valid && s_in_ready) void'(q.pop_front());
        if (!aresetn) s_in_valid <= 1'b0;
        else if (!s_in_valid || s_in_ready) begin
            if (q.size() != 0 && !(slow && $urandom_range(1) == 0)) begin
                s_in_valid <= 1'b1;
                s_in_data  <= q[0];
            end else begin
                s_in_valid <= 1'b0;
                s_in_data  <= ~s_in_data;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tcad_decoder_props.sv
/* port checker for the decoder.
   assumes: bound into every tcad_decoder instance. */
`timescale 1ns/1ps
`default_nettype none
module tcad_decoder_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_in_valid,
    input wire logic        s_in_ready,
    input wire logic        m_out_valid,
    input wire logic        m_out_ready,
    input wire logic        m_out_buf_end,
    input wire logic [31:0] m_out_data,
    input wire logic [3:0]  m_out_lanes,
    input wire logic        host_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // shorthand for stream and write takes
    wire tk = s_in_valid && s_in_ready;
    wire wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    AST_WR_RESP: assert property (wt |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    AST_WR_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stuck");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response stuck");
    AST_OUT_HOLD: assert property (m_out_valid && !m_out_ready |=> m_out_valid
        && $stable(m_out_data) && $stable(m_out_lanes)) else $error("output changed in stall");
    AST_LANES: assert property (m_out_valid |-> m_out_lanes inside {4'h1, 4'h2, 4'h3,
        4'h4, 4'h6, 4'h7, 4'h8, 4'hc, 4'he, 4'hf}) else $error("lanes not contiguous");
    AST_IRQ_RISE: assert property ($rose(host_irq) |-> $past(tk) || $past(tk, 2)
        || $past(tk, 3) || s_axi_bvalid)
        else $error("interrupt without cause");
    AST_IRQ_FALL: assert property ($fell(host_irq) |-> s_axi_bvalid)
        else $error("interrupt dropped without write");
    // main scenarios reached
    cover property (m_out_valid && m_out_ready && m_out_buf_end);
    cover property ($rose(host_irq));
    cover property (s_in_valid && !s_in_ready);
endmodule
bind tcad_decoder tcad_decoder_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_in_valid, .s_in_ready, .m_out_valid, .m_out_ready,
    .m_out_buf_end, .m_out_data, .m_out_lanes, .host_irq);
`default_nettype wire

//--- test/tb.sv
/* self-checking bench: host model feeds buffers, bench drains and reads registers.
   assumes: host model and checker compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcad_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, stall, lb;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        s_in_valid, s_in_ready, m_out_valid, m_out_ready, host_irq;
    logic        m_out_first_seg, m_out_last_seg, m_out_buf_end;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, s_in_data, m_out_data, rd, cmd;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  m_out_lanes;
    logic [10:0] e, expq[$];
    int          bad_count, check_count;

    tcad_decoder #(.FIFO_DEPTH(4)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
        .s_in_data, .s_in_valid, .s_in_ready, .m_out_data, .m_out_lanes, .m_out_first_seg,
        .m_out_last_seg, .m_out_buf_end, .m_out_valid, .m_out_ready, .host_irq);
    tcad_host_model u_host (.aclk, .aresetn, .s_in_data, .s_in_valid, .s_in_ready);

    // 100 ns clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one bounded clock step; a wait that runs out ends the run
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 3000) begin
            bad_count++;
            summarize();
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(r));
    endtask

    task automatic axr(input logic [7:0] a, input logic [1:0] r);
        int n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'(r));
    endtask

    // queue one buffer; expected bytes carry segment flags and the end mark
    task automatic send(input bit irq, input logic [1:0] al, input int off, input int sz,
                        input logic [4:0] rsv);
        int d, t;
        logic [31:0] w;
        logic fs, ls;
        d = (off + sz + 3) / 4;
        t = (al == ALIGN_16B) ? (d + 3) / 4 * 4 : (al == ALIGN_32B) ? (d + 7) / 8 * 8 : d;
        fs = 1'($urandom);
        ls = 1'($urandom);
        cmd = {irq, rsv, al, 3'h0, 5'(off), 2'h0, fs, ls, 1'b0, 11'(sz)};
        u_host.q.push_back(cmd);
        u_host.q.push_back($urandom);
        for (int i = 0; i < 4 * t; i++) begin
            if (i % 4 == 0) w = $urandom;
            if (i >= off && i < off + sz)
                expq.push_back({fs, ls, i == off + sz - 1 && t == d, w[8*(i%4)+:8]});
            if (i % 4 == 3) u_host.q.push_back(w);
        end
    endtask

    // drain with random stalls; every valid lane pops one expected byte
    always @(posedge aclk) begin
        m_out_ready <= !stall && $urandom_range(3) != 0;
        if (aresetn && m_out_valid && m_out_ready) begin
            for (int j = 0; j < 4; j++) begin
                if (m_out_lanes[j]) begin
                    e = expq.size() != 0 ? expq.pop_front() : 'x;
                    chk(32'({m_out_first_seg, m_out_last_seg, m_out_data[8*j+:8]}),
                        32'({e[10:9], e[7:0]}));
                    lb = e[8];
                end
            end
            chk(32'(m_out_buf_end), 32'(lb));
        end
    end

    initial begin
        int n;
        logic [1:0] al;
        bit irq, en;
        void'($urandom(32'h2189));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, stall, m_out_ready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(REG_CTRL, RESP_OKAY);
        chk(rd, 32'h0);
        axr(8'h10, RESP_SLVERR);
        chk(rd, 32'h0);
        axw(8'h10, 32'h1, RESP_SLVERR);
        for (int k = 0; k < 24; k++) begin
            irq = 1'($urandom);
            en = 1'($urandom);
            al = (k < 4) ? 2'(k) : 2'($urandom_range(2));
            u_host.slow = (k >= 12);
            axw(REG_CTRL, 32'(en), RESP_OKAY);
            send(irq, al, (k == 4) ? 31 : $urandom_range(31), (k == 5) ? 1 : $urandom_range(40, 1),
                 (k == 6) ? 5'h11 : 5'h0);
            n = 0;
            while (u_host.q.size() != 0 || expq.size() != 0) tick(n);
            repeat (3) @(posedge aclk);
            chk(32'(host_irq), 32'(irq & en));
            axr(REG_STATUS, RESP_OKAY);
            chk(rd & 32'hf, {28'h0, 1'b0, k == 6, al == ALIGN_RSV, irq});
            axr(REG_LAST_CMDA, RESP_OKAY);
            chk(rd, cmd);
            axr(REG_BUF_COUNT, RESP_OKAY);
            chk(rd, 32'(k + 1));
            axw(REG_STATUS, 32'h7, RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk(32'(host_irq), 32'h0);
        end
        // consumer stalled: the fifo fills and the host is held back
        stall <= 1'b1;
        u_host.slow = 1'b0;
        send(1'b0, ALIGN_32B, 3, 60, 5'h0);
        send(1'b1, ALIGN_16B, 0, 9, 5'h0);
        repeat (30) @(posedge aclk);
        chk(32'(u_host.q.size() != 0), 32'h1);
        stall <= 1'b0;
        n = 0;
        while (u_host.q.size() != 0 || expq.size() != 0) tick(n);
        chk(32'(expq.size()), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
